// [logic/slm_sequencer.sv]
`include "slm_map.svh"
`timescale 1ns/1ps
`default_nettype none
module slm_sequencer import slm_pkg::*; (
   input wire logic clk,
   input wire logic rstn,
   input wire logic linkClk,
   input wire slmReq_t linkReq,
   output logic cmdBusy,
   output logic [15:0] rdData,
   output logic rdValid,
   input wire logic controlPin,
   input wire logic enablePin,
   input wire logic fbModePin,
   input wire logic [15:0] measVout,
   input wire logic [15:0] measTemp,
   input wire logic [15:0] targetVout,
   input wire logic [11:0] targetCode,
   input wire logic [11:0] feedbackCode,
   output logic supplyEnableOut,
   output logic dacSwitchClosed,
   output logic [11:0] dacCode,
   output logic smbAlertOe
);
   slmCore_t s_q, s_d;
   slmLink_t l_q, l_d;
   logic [1:0] linkRst_q;
   logic reqNew, wrNow, clrNow, opWr, opImm, startReq, softReq;
   logic run, fb, usTick, dlyTick, stepNow, shut;
   logic evOvF, evOvW, evUvF, evUvW, evOtF, evOtW, evCml;
   logic vMask, uvLive, other, tmpAny, voutAny;
   logic [15:0] riseRaw, riseEff, fallEff, rampLen, rdMux;
   logic [16:0] accN;
   logic [7:0] statByte;
   logic [5:0] volFlags;

   // Summary bits shared by the status views
   assign other = s_q.flg.ovW | s_q.flg.uvW | s_q.flg.uvF;
   assign tmpAny = s_q.flg.otF | s_q.flg.otW;
   assign voutAny = s_q.flg.ovF | other;
   assign statByte = {1'b0, ~s_q.supplyEn, s_q.flg.ovF, 2'b00, tmpAny,
                      s_q.flg.comm_memory_logic_flag, other};
   assign volFlags = {s_q.flg.ovF, s_q.flg.ovW, s_q.flg.uvF, s_q.flg.uvW,
                      s_q.flg.otF, s_q.flg.otW};

   // Command decode; request fields are stable while the toggle is pending
   assign reqNew = s_q.reqS[1] ^ s_q.reqS[2];
   assign wrNow = reqNew & l_q.req.wr;
   assign clrNow = wrNow & (l_q.req.cmd == `SLM_CMD_CLEAR);
   assign opWr = wrNow & (l_q.req.cmd == `SLM_CMD_OPERATION);
   assign opImm = opWr & ~l_q.req.data[`SLM_OP_ON] & ~l_q.req.data[`SLM_OP_SOFT];
   assign run = s_q.ctl[1] & s_q.en[1];
   assign fb = s_q.fb[1];
   assign startReq = (opWr & l_q.req.data[`SLM_OP_ON]) | (run & ~s_q.runPrev);
   assign softReq = (opWr & ~l_q.req.data[`SLM_OP_ON] & l_q.req.data[`SLM_OP_SOFT])
                    | (~run & s_q.runPrev);

   // Effective ramp lengths in microsecond steps
   assign riseRaw = fb ? {2'b00, s_q.tim[1][13:0]} : s_q.tim[1];
   assign riseEff = (riseRaw < `SLM_RAMP_MIN) ? `SLM_RAMP_MIN : riseRaw;
   assign fallEff = (s_q.tim[3] < `SLM_RAMP_MIN) ? `SLM_RAMP_MIN : s_q.tim[3];
   assign rampLen = (s_q.st == SLM_FALL) ? fallEff : riseEff;
   assign usTick = (s_q.presc == 5'(`SLM_STEP_CYC - 1));
   assign dlyTick = usTick & (s_q.sub == `SLM_DLY_STEPS - 7'h01);

   // Limit checks; undervoltage only counts once the output has arrived
   assign vMask = (s_q.st == SLM_RISE);
   assign uvLive = (s_q.st == SLM_ON) & s_q.reached;
   assign evOvF = ~vMask & (measVout > s_q.lim[0]);
   assign evOvW = ~vMask & (measVout > s_q.lim[1]);
   assign evUvW = uvLive & (measVout < s_q.lim[2]);
   assign evUvF = uvLive & (measVout < s_q.lim[3]);
   assign evOtF = ~vMask & ($signed(measTemp) > $signed(s_q.lim[4]));
   assign evOtW = ~vMask & ($signed(measTemp) > $signed(s_q.lim[5]));
   assign shut = (evOvF & s_q.resp[0]) | (evUvF & s_q.resp[1])
                 | (evOtF & s_q.resp[2]);

   // Read view of the register map
   always_comb begin
      unique case (l_q.req.cmd)
         `SLM_CMD_OV_FAULT: rdMux = s_q.lim[0];
         `SLM_CMD_OVERVOLTAGE_WARNING_FLAG: rdMux = s_q.lim[1];
         `SLM_CMD_UNDERVOLTAGE_WARNING_FLAG: rdMux = s_q.lim[2];
         `SLM_CMD_UNDERVOLTAGE_FAULT_FLAG: rdMux = s_q.lim[3];
         `SLM_CMD_OVERTEMP_FAULT_FLAG: rdMux = s_q.lim[4];
         `SLM_CMD_OVERTEMP_WARNING_FLAG: rdMux = s_q.lim[5];
         `SLM_CMD_TON_DLY: rdMux = s_q.tim[0];
         `SLM_CMD_TON_RAMP: rdMux = s_q.tim[1];
         `SLM_CMD_TOFF_DLY: rdMux = s_q.tim[2];
         `SLM_CMD_TOFF_RAMP: rdMux = s_q.tim[3];
         `SLM_CMD_FAULT_RESP: rdMux = {13'h0000, s_q.resp};
         `SLM_CMD_STAT_BYTE: rdMux = {8'h00, statByte};
         `SLM_CMD_STAT_WORD: rdMux = {voutAny, 2'b00, other, 4'h0, statByte};
         `SLM_CMD_STAT_OUTPUT_VOLTAGE_SUMMARY_FLAG: rdMux = {8'h00, volFlags[5:2], 4'h0};
         `SLM_CMD_STAT_TEMP: rdMux = {8'h00, volFlags[1:0], 6'h00};
         `SLM_CMD_STAT_VEND: rdMux = {13'h0000, s_q.flg.uvF, s_q.flg.uvW,
                                      s_q.flg.ovW};
         `SLM_CMD_VEND_WORD: rdMux = {8'h00, s_q.flg.otW, s_q.flg.otF,
                                      s_q.flg.uvW, s_q.flg.uvF, s_q.flg.ovW,
                                      s_q.flg.ovF, tmpAny, other};
         default: rdMux = 16'h0000;
      endcase
   end

   // Core next state: sequencer, ramps, flags and register file
   always_comb begin
      s_d = s_q;
      evCml = 1'b0;
      stepNow = 1'b0;
      accN = s_q.acc + {5'h00, s_q.base};
      if (accN >= {1'b0, rampLen}) begin
         accN = accN - {1'b0, rampLen};
         stepNow = 1'b1;
      end
      // Pin synchronisers, two flops before use
      s_d.ctl = {s_q.ctl[0], controlPin};
      s_d.en = {s_q.en[0], enablePin};
      s_d.fb = {s_q.fb[0], fbModePin};
      s_d.runPrev = run;
      s_d.reqS = {s_q.reqS[1:0], l_q.reqTog};
      s_d.presc = usTick ? 5'h00 : s_q.presc + 5'h01;
      if (usTick) begin
         s_d.sub = (s_q.sub == `SLM_DLY_STEPS - 7'h01) ? 7'h00 : s_q.sub + 7'h01;
      end
      // Register access answered one cycle after the request is seen
      if (reqNew) begin
         s_d.ackTog = ~s_q.ackTog;
         s_d.rdBuf = rdMux;
      end
      if (wrNow) begin
         unique case (l_q.req.cmd)
            `SLM_CMD_OV_FAULT: s_d.lim[0] = l_q.req.data;
            `SLM_CMD_OVERVOLTAGE_WARNING_FLAG: s_d.lim[1] = l_q.req.data;
            `SLM_CMD_UNDERVOLTAGE_WARNING_FLAG: s_d.lim[2] = l_q.req.data;
            `SLM_CMD_UNDERVOLTAGE_FAULT_FLAG: s_d.lim[3] = l_q.req.data;
            `SLM_CMD_OVERTEMP_FAULT_FLAG: s_d.lim[4] = l_q.req.data;
            `SLM_CMD_OVERTEMP_WARNING_FLAG: s_d.lim[5] = l_q.req.data;
            `SLM_CMD_TON_DLY: s_d.tim[0] = l_q.req.data;
            `SLM_CMD_TON_RAMP: s_d.tim[1] = l_q.req.data;
            `SLM_CMD_TOFF_DLY: s_d.tim[2] = l_q.req.data;
            `SLM_CMD_TOFF_RAMP: s_d.tim[3] = l_q.req.data;
            `SLM_CMD_FAULT_RESP: s_d.resp = l_q.req.data[2:0];
            default: ;
         endcase
      end
      // Delays count 0.1 ms steps, ramps count 1 us steps
      if ((s_q.st == SLM_DLY_ON || s_q.st == SLM_DLY_OFF) && dlyTick) begin
         s_d.timer = s_q.timer + 16'h0001;
      end
      if ((s_q.st == SLM_RISE || s_q.st == SLM_FALL) && usTick) begin
         s_d.timer = s_q.timer + 16'h0001;
         s_d.acc = accN;
      end
      unique case (s_q.st)
         SLM_OFF: begin
            if (startReq) begin
               s_d.st = SLM_DLY_ON;
            end
         end
         SLM_DLY_ON: begin
            if (softReq) begin
               s_d.st = SLM_OFF;
            end else if (s_q.timer >= s_q.tim[0]) begin
               s_d.st = SLM_RISE;
               s_d.supplyEn = 1'b1;
               s_d.sw = 1'b0;
               s_d.acc = 17'h00000;
               s_d.dac = 12'h000;
               s_d.base = targetCode;
               if (!fb && targetCode > `SLM_DAC_MAX) begin
                  s_d.base = `SLM_DAC_MAX;
                  evCml = 1'b1;
               end
            end
         end
         SLM_RISE: begin
            if (usTick && stepNow && !fb && s_q.dac < s_q.base) begin
               s_d.dac = s_q.dac + 12'h001;
            end
            if (softReq) begin
               s_d.st = SLM_DLY_OFF;
            end else if (s_q.timer >= riseEff) begin
               s_d.st = SLM_ON;
               s_d.dac = fb ? feedbackCode : s_q.base;
               s_d.sw = 1'b1;
               s_d.reached = 1'b0;
            end
         end
         SLM_ON: begin
            if (measVout >= targetVout) begin
               s_d.reached = 1'b1;
            end
            if (softReq) begin
               s_d.st = SLM_DLY_OFF;
            end
         end
         SLM_DLY_OFF: begin
            if (s_q.timer >= s_q.tim[2]) begin
               if (fb) begin
                  s_d.st = SLM_OFF;
                  s_d.supplyEn = 1'b0;
                  s_d.sw = 1'b0;
               end else begin
                  s_d.st = SLM_FALL;
                  s_d.acc = 17'h00000;
                  s_d.base = s_q.dac;
                  evCml = (s_q.dac > `SLM_DAC_MAX);
               end
            end
         end
         SLM_FALL: begin
            if (usTick && stepNow && s_q.dac != 12'h000) begin
               s_d.dac = s_q.dac - 12'h001;
            end
            if (s_q.timer >= fallEff) begin
               s_d.st = SLM_OFF;
               s_d.dac = 12'h000;
               s_d.supplyEn = 1'b0;
               s_d.sw = 1'b0;
            end
         end
         default: begin
            s_d.st = SLM_OFF;
            s_d.supplyEn = 1'b0;
         end
      endcase
      // Immediate off and shut-down responses override everything in every state but SLM_OFF
      if ((opImm || shut) && s_q.st != SLM_OFF) begin
         s_d.st = SLM_OFF;
         s_d.supplyEn = 1'b0;
         s_d.sw = 1'b0;
         s_d.dac = 12'h000;
      end
      if (s_d.st != s_q.st) begin
         s_d.timer = 16'h0000;
         // Fresh time base per state, else a stale phase cuts delays short
         s_d.presc = 5'h00;
         s_d.sub = 7'h00;
      end
      // Sticky flags: a new event wins over a clear in the same cycle
      s_d.flg = clrNow ? '0 : s_q.flg;
      s_d.flg.ovF = s_d.flg.ovF | evOvF;
      s_d.flg.ovW = s_d.flg.ovW | evOvW;
      s_d.flg.uvF = s_d.flg.uvF | evUvF;
      s_d.flg.uvW = s_d.flg.uvW | evUvW;
      s_d.flg.otF = s_d.flg.otF | evOtF;
      s_d.flg.otW = s_d.flg.otW | evOtW;
      s_d.flg.comm_memory_logic_flag = s_d.flg.comm_memory_logic_flag | evCml;
      s_d.alert = |s_d.flg;
   end

   // Core register; limits reset to zero
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.tim[1] <= `SLM_RAMP_MIN;
         s_q.tim[3] <= `SLM_RAMP_MIN;
         s_q.st <= SLM_OFF;
      end else begin
         s_q <= s_d;
      end
   end

   // Reset brought into the link domain through two flops
   always_ff @(posedge linkClk) begin
      linkRst_q <= {linkRst_q[0], rstn};
   end

   // Link side: one request in flight, released by the returning toggle
   always_comb begin
      l_d = l_q;
      l_d.ackS = {l_q.ackS[0], s_q.ackTog};
      l_d.ackSeen = l_q.ackS[1];
      l_d.rdValid = 1'b0;
      if (l_q.ackS[1] ^ l_q.ackSeen) begin
         l_d.busy = 1'b0;
         l_d.rdValid = l_q.req.rd;
         if (l_q.req.rd) begin
            l_d.rdData = s_q.rdBuf;
         end
      end else if (!l_q.busy && (linkReq.wr || linkReq.rd)) begin
         l_d.req = linkReq;
         l_d.reqTog = ~l_q.reqTog;
         l_d.busy = 1'b1;
      end
   end

   always_ff @(posedge linkClk) begin
      if (!linkRst_q[1]) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   assign cmdBusy = l_q.busy;
   assign rdData = l_q.rdData;
   assign rdValid = l_q.rdValid;
   assign supplyEnableOut = s_q.supplyEn;
   assign dacSwitchClosed = s_q.sw;
   assign dacCode = s_q.dac;
   assign smbAlertOe = s_q.alert;

   // Checks on the core domain
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence fbDelayEnd;
      s_q.st == SLM_DLY_OFF && fb && s_q.timer >= s_q.tim[2] && !opImm && !shut;
   endsequence
   sequence riseEntry;
      s_q.st == SLM_DLY_ON && !softReq && s_q.timer >= s_q.tim[0] && !opImm && !shut;
   endsequence

   a_ov_fault_alert: assert property ((s_q.st != SLM_RISE && measVout > s_q.lim[0])
      |=> s_q.flg.ovF && smbAlertOe) else $error("ov fault not flagged");
   a_overtemp_fault_flag_flag: assert property ((s_q.st != SLM_RISE
      && $signed(measTemp) > $signed(s_q.lim[4]))
      |=> s_q.flg.otF && statByte[2]) else $error("overtemp_fault_flag not flagged");
   a_delay_enable_low: assert property (s_q.st == SLM_DLY_ON |-> !supplyEnableOut)
      else $error("enable during delay");
   a_rise_enable: assert property (riseEntry |=> supplyEnableOut
      && s_q.st == SLM_RISE) else $error("rise not entered");
   a_rise_masked: assert property ((s_q.st == SLM_RISE && !clrNow)
      |=> volFlags == $past(volFlags)) else $error("flag set in rise");
   a_uv_masked: assert property ((!uvLive && !s_q.flg.uvF && !s_q.flg.uvW)
      |=> !s_q.flg.uvF && !s_q.flg.uvW) else $error("uv not masked");
   a_imm_off: assert property ((opImm && s_q.st != SLM_OFF)
      |=> !supplyEnableOut && s_q.st == SLM_OFF) else $error("immediate off late");
   a_fb_open_rise: assert property ((fb && s_q.st == SLM_RISE) |-> !dacSwitchClosed)
      else $error("switch closed in rise");
   a_fb_off_now: assert property (fbDelayEnd |=> !supplyEnableOut && !dacSwitchClosed
      && s_q.st == SLM_OFF) else $error("fb turn-off late");
   a_rise_min: assert property (riseEff >= `SLM_RAMP_MIN)
      else $error("rise below minimum");
   a_flag_sticky: assert property ((s_q.flg.ovF && !clrNow) |=> s_q.flg.ovF)
      else $error("flag lost");
   a_cml_range: assert property ((riseEntry ##0 (!fb && targetCode > `SLM_DAC_MAX))
      |=> s_q.flg.comm_memory_logic_flag && smbAlertOe) else $error("range not flagged");
endmodule : slm_sequencer
`default_nettype wire

// [logic/slm_map.svh]
// Behaviour
// - Overvoltage fault sets flags, responds, alerts
// - Overvoltage warning sets flags, alerts
// - Undervoltage warning sets flags, alerts
// - Undervoltage warning masked until reached, off
// - Undervoltage fault sets flags, responds, alerts
// - Undervoltage fault masked until reached, off
// - Overtemperature fault sets flags, responds, alerts
// - Overtemperature warning sets flags, no response
// - Settings two bytes, limits reset zero
// - Enable held off during turn-on delay
// - Undervoltage masked during turn-on delay
// - All limits masked during rise
// - Ramp code beyond 4090 sets comm flag
// - Feedback mode: switch open, then match, close
// - Feedback mode uses low 14 rise bits
// - Rise below 0.01ms treated as 0.01ms
// - Soft stop waits turn-off delay
// - Immediate off skips delay and fall
// - Soft stop ramps down over fall time
// - Feedback mode skips fall, opens at once
// - Status byte bits 5, 2, 1
`ifndef SLM_MAP_SVH
`define SLM_MAP_SVH
`define SLM_CMD_OPERATION 8'h01
`define SLM_CMD_CLEAR 8'h03
`define SLM_CMD_OV_FAULT 8'h40
`define SLM_CMD_OVERVOLTAGE_WARNING_FLAG 8'h42
`define SLM_CMD_UNDERVOLTAGE_WARNING_FLAG 8'h43
`define SLM_CMD_UNDERVOLTAGE_FAULT_FLAG 8'h44
`define SLM_CMD_OVERTEMP_FAULT_FLAG 8'h4F
`define SLM_CMD_OVERTEMP_WARNING_FLAG 8'h51
`define SLM_CMD_TON_DLY 8'h60
`define SLM_CMD_TON_RAMP 8'h61
`define SLM_CMD_TOFF_DLY 8'h64
`define SLM_CMD_TOFF_RAMP 8'h65
`define SLM_CMD_STAT_BYTE 8'h78
`define SLM_CMD_STAT_WORD 8'h79
`define SLM_CMD_STAT_OUTPUT_VOLTAGE_SUMMARY_FLAG 8'h7A
`define SLM_CMD_STAT_TEMP 8'h7D
`define SLM_CMD_STAT_VEND 8'h80
`define SLM_CMD_FAULT_RESP 8'hD5
`define SLM_CMD_VEND_WORD 8'hD8
`define SLM_OP_ON 7
`define SLM_OP_SOFT 6
`define SLM_LIMIT_RESET 16'h0000
`define SLM_RAMP_MIN 16'h000A
`define SLM_DAC_MAX 12'hFFA
`define SLM_CLK_NS 50
`define SLM_STEP_NS 1000
`define SLM_STEP_CYC ((`SLM_STEP_NS + `SLM_CLK_NS - 1) / `SLM_CLK_NS)
`define SLM_DLY_STEPS 7'h64
`endif

// [logic/slm_pkg.sv]
package slm_pkg;
   typedef enum logic [2:0] {
      SLM_OFF = 3'h0,
      SLM_DLY_ON = 3'h1,
      SLM_RISE = 3'h3,
      SLM_ON = 3'h2,
      SLM_DLY_OFF = 3'h6,
      SLM_FALL = 3'h7
   } slmState_t;
   typedef struct packed {
      logic ovF, ovW, uvF, uvW, otF, otW, comm_memory_logic_flag;
   } slmFlags_t;
   typedef struct packed {
      logic [7:0] cmd;
      logic [15:0] data;
      logic wr;
      logic rd;
   } slmReq_t;
   typedef struct packed {
      logic [1:0] ctl, en, fb;
      logic runPrev;
      logic [2:0] reqS;
      logic ackTog;
      logic [15:0] rdBuf;
      logic [5:0][15:0] lim;
      logic [3:0][15:0] tim;
      logic [2:0] resp;
      slmFlags_t flg;
      slmState_t st;
      logic [4:0] presc;
      logic [6:0] sub;
      logic [15:0] timer;
      logic [16:0] acc;
      logic [11:0] base, dac;
      logic supplyEn, sw, reached, alert;
   } slmCore_t;
   typedef struct packed {
      logic [1:0] ackS;
      logic ackSeen, reqTog, busy, rdValid;
      slmReq_t req;
      logic [15:0] rdData;
   } slmLink_t;
endpackage : slm_pkg

// [test/slm_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Command-link host: one word per request, never overlapping
module slm_host_model import slm_pkg::*; (
   input wire logic linkClk,
   input wire logic cmdBusy,
   input wire logic [15:0] rdData,
   input wire logic rdValid,
   output var slmReq_t linkReq
);
   initial linkReq = '{cmd: 8'h00, data: 16'h0000, wr: 1'b0, rd: 1'b0};

   // Request held until busy shows the take; released lines carry the inverse
   task automatic xfer(input logic [7:0] cmd, input logic [15:0] data, input logic rd,
         output logic [15:0] q, output logic ok);
      int n;
      ok = 1'b0;
      if (cmd == 8'h65 && data < 16'h0064) begin
         data = 16'h0064; // Fall never programmed under 0.1 ms
      end
      @(posedge linkClk);
      #1;
      linkReq = '{cmd: cmd, data: data, wr: !rd, rd: rd}; // Whole two-byte word
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge linkClk);
         #1;
         ok = (cmdBusy === 1'b1);
      end
      linkReq = '{cmd: ~cmd, data: ~data, wr: 1'b0, rd: 1'b0};
      if (ok) begin
         ok = 1'b0;
         // Read word is valid on the cycle busy falls
         for (n = 0; n < 40 && !ok; n++) begin
            @(posedge linkClk);
            #1;
            ok = (cmdBusy === 1'b0) && (rdValid === 1'b1 || !rd);
         end
      end
      q = rdData;
   endtask : xfer
endmodule : slm_host_model
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb import slm_pkg::*;;
   logic clk = 1'b0;
   logic linkClk = 1'b0;
   logic rstn = 1'b0;
   logic controlPin = 1'b0;
   logic enablePin = 1'b0;
   logic fbModePin = 1'b0;
   logic [15:0] measVout = 16'h0000;
   logic [15:0] measTemp = 16'h0000;
   logic [15:0] targetVout = 16'h01F4;
   logic [11:0] targetCode = 12'h800;
   logic [11:0] feedbackCode = 12'h5A5;
   slmReq_t linkReq;
   logic cmdBusy, rdValid, supplyEnableOut, dacSwitchClosed, smbAlertOe, alertN;
   logic [15:0] rdData;
   logic [11:0] dacCode;
   int errorCnt = 0;
   int nChecks = 0;
   // Open-drain alert wire with pull-up
   assign alertN = smbAlertOe ? 1'b0 : 1'b1;

   initial forever #25 clk = ~clk;
   // Link clock offset by 7 ns at a 48 ns period; its rising edges still meet the core clock's every 1200 ns
   initial begin
      #7;
      forever #24 linkClk = ~linkClk;
   end

   slm_sequencer DUT (
      .clk(clk),
      .rstn(rstn),
      .linkClk(linkClk),
      .linkReq(linkReq),
      .cmdBusy(cmdBusy),
      .rdData(rdData),
      .rdValid(rdValid),
      .controlPin(controlPin),
      .enablePin(enablePin),
      .fbModePin(fbModePin),
      .measVout(measVout),
      .measTemp(measTemp),
      .targetVout(targetVout),
      .targetCode(targetCode),
      .feedbackCode(feedbackCode),
      .supplyEnableOut(supplyEnableOut),
      .dacSwitchClosed(dacSwitchClosed),
      .dacCode(dacCode),
      .smbAlertOe(smbAlertOe)
   );

   slm_host_model HOST (
      .linkClk(linkClk),
      .cmdBusy(cmdBusy),
      .rdData(rdData),
      .rdValid(rdValid),
      .linkReq(linkReq)
   );

   task automatic endSim;
      $display("checks %0d errors %0d", nChecks, errorCnt);
      if (errorCnt == 0 && nChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : endSim

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      nChecks++;
      if (got !== exp) begin
         errorCnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic chkb(input string what, input logic exp, input logic got);
      chk(what, {15'h0000, exp}, {15'h0000, got});
   endtask : chkb

   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      nChecks++;
      if (got < lo || got > hi) begin
         errorCnt++;
         $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk_rng

   // A hung link ends the run at once
   task automatic link(input logic [7:0] cmd, input logic [15:0] d, input logic rd,
         output logic [15:0] q);
      logic ok;
      HOST.xfer(cmd, d, rd, q, ok);
      if (!ok) begin
         errorCnt++;
         $display("[ERR] link %h expected done seen timeout", cmd);
         endSim();
      end
   endtask : link

   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      logic [15:0] q;
      link(cmd, d, 1'b0, q);
   endtask : wr

   task automatic rdc(input logic [7:0] cmd, input logic [15:0] exp);
      logic [15:0] q;
      link(cmd, 16'h0000, 1'b1, q);
      chk($sformatf("reg %h", cmd), exp, q);
   endtask : rdc

   // Counts core cycles until enable (0), switch (1) or dac-at-target (2) equals val
   task automatic wait_out(input int sel, input logic val, input int lim, output int n);
      logic v;
      for (n = 0; n < lim; n++) begin
         @(posedge clk);
         #1;
         v = sel == 0 ? supplyEnableOut : sel == 1 ? dacSwitchClosed : dacCode === targetCode;
         if (v === val) return;
      end
      errorCnt++;
      $display("[ERR] output %0d expected %b seen timeout", sel, val);
      endSim();
   endtask : wait_out

   task automatic drive(input logic [15:0] v, input logic [15:0] t);
      @(posedge clk);
      #1;
      measVout = v;
      measTemp = t;
      repeat (3) @(posedge clk);
   endtask : drive

   task automatic s_regs;
      logic [7:0] a [10] = '{8'h40, 8'h42, 8'h43, 8'h44, 8'h4F, 8'h51, 8'h60, 8'h61, 8'h64, 8'h65};
      logic [15:0] v [10] = '{16'h0384, 16'h02BC, 16'h00C8, 16'h0064, 16'h012C, 16'h00C8,
         16'h0001, 16'h0003, 16'h0001, 16'h0064};
      for (int i = 0; i < 10; i++) rdc(a[i], (i == 7 || i == 9) ? 16'h000A : 16'h0000);
      wr(8'h30, 16'h1234);
      rdc(8'h30, 16'h0000);
      for (int i = 0; i < 10; i++) wr(a[i], 16'hA50F ^ 16'(i));
      for (int i = 0; i < 10; i++) rdc(a[i], 16'hA50F ^ 16'(i));
      for (int i = 0; i < 10; i++) wr(a[i], v[i]);
      // Negative temperature limits above tripped both flags; they stay until cleared
      rdc(8'h7D, 16'h00C0);
      wr(8'h03, 16'h0000);
      rdc(8'h78, 16'h0040);
   endtask : s_regs

   task automatic s_turn_on;
      int n;
      wr(8'h01, 16'h0080);
      wait_out(0, 1'b1, 5000, n);
      chk_rng("turn-on delay", 1960, 2010, n);
      measTemp = 16'h00FA; // Above warning while the ramp masks it
      repeat (60) @(posedge clk);
      #1;
      measTemp = 16'h0000;
      chkb("switch in rise", 1'b0, dacSwitchClosed);
      wait_out(1, 1'b1, 400, n);
      chk_rng("rise time", 110, 230, n);
      chk("dac at on", {4'h0, targetCode}, {4'h0, dacCode});
      rdc(8'h7D, 16'h0000);
      rdc(8'h7A, 16'h0000);
      chkb("alert", 1'b1, alertN);
   endtask : s_turn_on

   task automatic s_uv;
      drive(16'h01F4, 16'h0000);
      drive(16'h0032, 16'h0000);
      rdc(8'h7A, 16'h0030);
      rdc(8'h80, 16'h0006);
      rdc(8'h78, 16'h0001);
      rdc(8'h79, 16'h9001);
      rdc(8'hD8, 16'h0031);
      chkb("alert", 1'b0, alertN);
      chkb("enable", 1'b1, supplyEnableOut);
      drive(16'h01F4, 16'h0000);
      rdc(8'h7A, 16'h0030);
      wr(8'h03, 16'h0000);
      rdc(8'h7A, 16'h0000);
   endtask : s_uv

   task automatic s_ovot;
      int n;
      drive(16'h02EE, 16'h0000);
      rdc(8'h7A, 16'h0040);
      rdc(8'h80, 16'h0001);
      rdc(8'h78, 16'h0001);
      drive(16'h03E8, 16'h0000);
      rdc(8'h7A, 16'h00C0);
      rdc(8'h79, 16'h9021);
      drive(16'h01F4, 16'h00FA);
      rdc(8'h7D, 16'h0040);
      chkb("enable", 1'b1, supplyEnableOut);
      drive(16'h01F4, 16'h015E);
      rdc(8'h7D, 16'h00C0);
      rdc(8'hD8, 16'h00CF);
      rdc(8'h78, 16'h0025);
      chkb("alert", 1'b0, alertN);
      wr(8'hD5, 16'h0004);
      wr(8'h03, 16'h0000);
      wait_out(0, 1'b0, 100, n);
      rdc(8'h78, 16'h0044);
      drive(16'h01F4, 16'h0000);
      wr(8'hD5, 16'h0000);
      wr(8'h03, 16'h0000);
   endtask : s_ovot

   task automatic s_stop;
      int n;
      wr(8'h01, 16'h0080);
      wait_out(1, 1'b1, 6000, n);
      wr(8'h01, 16'h0040);
      repeat (1900) @(posedge clk);
      #1;
      chkb("held in delay", 1'b1, supplyEnableOut);
      wait_out(2, 1'b0, 2300, n);
      chk_rng("turn-off delay", 50, 2200, n);
      wait_out(0, 1'b0, 2500, n);
      chk_rng("fall time", 1850, 2150, n);
      chk("dac at off", 16'h0000, {4'h0, dacCode});
      wr(8'h01, 16'h0080);
      wait_out(1, 1'b1, 6000, n);
      wr(8'h01, 16'h0000);
      wait_out(0, 1'b0, 40, n);
   endtask : s_stop

   task automatic s_pin;
      int n;
      @(posedge clk);
      #1;
      targetCode = 12'hFFF;
      controlPin = 1'b1;
      enablePin = 1'b1;
      wait_out(0, 1'b1, 5000, n);
      chk_rng("pin start delay", 1990, 2015, n);
      wait_out(1, 1'b1, 400, n);
      rdc(8'h78, 16'h0002);
      chkb("dac in range", 1'b1, dacCode <= 12'hFFA);
      @(posedge clk);
      #1;
      enablePin = 1'b0;
      repeat (1900) @(posedge clk);
      #1;
      chkb("pin stop delay", 1'b1, supplyEnableOut);
      wait_out(0, 1'b0, 4500, n);
      rdc(8'h78, 16'h0042);
      @(posedge clk);
      #1;
      controlPin = 1'b0;
      targetCode = 12'h800;
      wr(8'h03, 16'h0000);
   endtask : s_pin

   task automatic s_fb;
      int n;
      @(posedge clk);
      #1;
      fbModePin = 1'b1;
      wr(8'h61, 16'hC014);
      wr(8'h64, 16'h0000);
      wr(8'h01, 16'h0080);
      wait_out(0, 1'b1, 5000, n);
      chkb("switch in rise", 1'b0, dacSwitchClosed);
      wait_out(1, 1'b1, 1000, n);
      chk_rng("fb rise time", 380, 470, n);
      chk("dac matches node", {4'h0, feedbackCode}, {4'h0, dacCode});
      wr(8'h01, 16'h0040);
      wait_out(0, 1'b0, 1000, n);
      chkb("switch at off", 1'b0, dacSwitchClosed);
   endtask : s_fb

   initial begin
      repeat (4) @(posedge clk);
      #1;
      rstn = 1'b1;
      repeat (6) @(posedge linkClk);
      s_regs();
      s_turn_on();
      s_uv();
      s_ovot();
      s_stop();
      s_pin();
      s_fb();
      endSim();
   end
endmodule : tb
`default_nettype wire
